// ===== inc/mmu_defs.svh
// Constants of the memory management unit: offsets, fields, reset values.
`ifndef MMU_DEFS_SVH
`define MMU_DEFS_SVH
`define MMU_VADDR_W 16
`define MMU_PADDR_W 22
`define MMU_SEG_W 6
`define MMU_PAGE_W 8
`define MMU_OFFS_W 14
`define MMU_MMU_PAGE 6'h15
`define MMU_PAGE0_OFS 8'hF0
`define MMU_PAGE1_OFS 8'hF1
`define MMU_PAGE2_OFS 8'hF2
`define MMU_PAGE3_OFS 8'hF3
`define MMU_CODE_SEG_OFS 8'hF4
`define MMU_EXT_MODE_OFS 8'hF6
`define MMU_IRQ_SEG_OFS 8'hF8
`define MMU_DMA_SEG_OFS 8'hF9
`define MMU_PAGE0_RELOC 8'hE0
`define MMU_PAGE3_RELOC 8'hE3
`define MMU_RELOC_BIT 5
`define MMU_PUSH_BIT 6
`define MMU_CODE_SEG_RESET 6'h00
`define MMU_RDATA_RESET 8'h00
`endif

// ===== inc/mmu_pkg.sv
// Types shared by the memory management unit modules.
package mmu_pkg;
    typedef enum logic [2:0] {
        MMU_KIND_FETCH = 3'h0,
        MMU_KIND_DATA = 3'h1,
        MMU_KIND_PMEM_DATA = 3'h2,
        MMU_KIND_IRQ_FETCH = 3'h3,
        MMU_KIND_DMA = 3'h4
    } mmu_kind_t;
    typedef enum logic [1:0] {
        MMU_CTX_NORMAL = 2'h0,
        MMU_CTX_IRQ_COMPAT = 2'h1,
        MMU_CTX_IRQ_PUSHED = 2'h2
    } mmu_ctx_t;
endpackage

// ===== inc/mmu_xl_if.sv
// Carrier between the register side and the address translator.
`timescale 1ns/1ps
`include "mmu_defs.svh"
interface mmu_xl_if;
    mmu_pkg::mmu_kind_t kind;
    logic [`MMU_VADDR_W-1:0] vaddr;
    logic [3:0][`MMU_PAGE_W-1:0] data_page;
    logic [`MMU_SEG_W-1:0] code_segment;
    logic [`MMU_SEG_W-1:0] interrupt_segment;
    logic [`MMU_SEG_W-1:0] dma_segment;
    logic dma_page_select;
    logic pmem_data_mode;
    logic irq_compat;
    logic [`MMU_PADDR_W-1:0] paddr;
    modport src (
        output kind, vaddr, data_page, code_segment, interrupt_segment,
        output dma_segment, dma_page_select, pmem_data_mode, irq_compat,
        input paddr
    );
    modport xl (
        input kind, vaddr, data_page, code_segment, interrupt_segment,
        input dma_segment, dma_page_select, pmem_data_mode, irq_compat,
        output paddr
    );
endinterface

// ===== verilog/mmu_xlate.sv
// Combinational translation of one virtual address to a physical one.
`timescale 1ns/1ps
`include "mmu_defs.svh"
module mmu_xlate (
    // Translation operands and result
    mmu_xl_if.xl xl
);
    logic [1:0] page_sel;
    logic [`MMU_SEG_W-1:0] seg;
    logic use_page;

    assign page_sel = xl.vaddr[`MMU_VADDR_W-1:`MMU_OFFS_W];

    always_comb begin
        use_page = 1'b0;
        seg = xl.code_segment;
        case (xl.kind)
            mmu_pkg::MMU_KIND_DATA: begin
                // After spm the core's data goes to code space.
                use_page = !xl.pmem_data_mode;
            end
            mmu_pkg::MMU_KIND_PMEM_DATA: begin
                seg = xl.code_segment;
            end
            mmu_pkg::MMU_KIND_IRQ_FETCH: begin
                if (xl.irq_compat) begin
                    seg = xl.interrupt_segment;
                end
            end
            mmu_pkg::MMU_KIND_FETCH: begin
                if (xl.irq_compat) begin
                    seg = xl.interrupt_segment;
                end
            end
            mmu_pkg::MMU_KIND_DMA: begin
                if (xl.dma_page_select) begin
                    seg = xl.dma_segment;
                end else begin
                    seg = xl.interrupt_segment;
                end
            end
            default: begin
                use_page = 1'b0;
            end
        endcase
    end

    always_comb begin
        if (use_page) begin
            xl.paddr = {xl.data_page[page_sel],
                        xl.vaddr[`MMU_OFFS_W-1:0]};
        end else begin
            xl.paddr = {seg, xl.vaddr};
        end
    end
endmodule

// ===== verilog/mmu_top.sv
// Memory management unit: translation registers and address extension.
`timescale 1ns/1ps
`include "mmu_defs.svh"
module mmu_top (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Access request from the core
    input wire logic acc_valid_i,
    input wire mmu_pkg::mmu_kind_t acc_kind_i,
    input wire logic [`MMU_VADDR_W-1:0] acc_vaddr_i,
    // Translated access to memories
    output logic phys_valid_o,
    output logic [`MMU_PADDR_W-1:0] phys_addr_o,
    output logic [`MMU_SEG_W-1:0] phys_segment_o,
    // Register file port
    input wire logic [7:0] reg_addr_i,
    input wire logic [5:0] reg_page_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_hit_o,
    // Instruction events from the core
    input wire logic far_load_i,
    input wire logic [`MMU_SEG_W-1:0] far_seg_i,
    input wire logic irq_entry_i,
    input wire logic iret_i,
    input wire logic [`MMU_SEG_W-1:0] iret_seg_i,
    input wire logic spm_i,
    input wire logic sdm_i,
    // DMA controller select
    input wire logic dma_page_select_i,
    // Status to the core and to the port registers
    output logic seg_push_o,
    output logic [`MMU_SEG_W-1:0] seg_push_val_o,
    output logic page_reloc_o,
    output logic [`MMU_SEG_W-1:0] code_segment_o
);
    logic [3:0][`MMU_PAGE_W-1:0] data_page;
    logic [`MMU_SEG_W-1:0] code_segment;
    logic [`MMU_SEG_W-1:0] interrupt_segment;
    logic [`MMU_SEG_W-1:0] dma_segment;
    logic page_register_relocation_bit;
    logic interrupt_segment_push_bit;
    logic pmem_data_mode;
    mmu_pkg::mmu_ctx_t ctx;
    mmu_pkg::mmu_ctx_t next_ctx;
    logic on_page21;
    logic dpr_hit;
    logic [1:0] dpr_idx;
    logic hit_code_seg;
    logic hit_ext_mode;
    logic hit_irq_seg;
    logic hit_dma_seg;
    logic any_hit;
    logic [7:0] next_rdata;
    logic [`MMU_SEG_W-1:0] next_code_segment;
    logic next_reloc;

    mmu_xl_if xlc ();

    // Register decode.
    assign on_page21 = (reg_page_i == `MMU_MMU_PAGE);

    always_comb begin
        dpr_hit = 1'b0;
        dpr_idx = reg_addr_i[1:0];
        if (page_register_relocation_bit) begin
            // Group E is unpaged, so the page pointer is not looked at.
            dpr_hit = (reg_addr_i >= `MMU_PAGE0_RELOC) &&
                      (reg_addr_i <= `MMU_PAGE3_RELOC);
        end else begin
            dpr_hit = on_page21 &&
                      (reg_addr_i >= `MMU_PAGE0_OFS) &&
                      (reg_addr_i <= `MMU_PAGE3_OFS);
        end
    end

    // The segment and mode registers never move off page 21.
    always_comb begin
        hit_code_seg = 1'b0;
        hit_ext_mode = 1'b0;
        hit_irq_seg = 1'b0;
        hit_dma_seg = 1'b0;
        if (on_page21) begin
            case (reg_addr_i)
                `MMU_CODE_SEG_OFS: begin
                    hit_code_seg = 1'b1;
                end
                `MMU_EXT_MODE_OFS: begin
                    hit_ext_mode = 1'b1;
                end
                `MMU_IRQ_SEG_OFS: begin
                    hit_irq_seg = 1'b1;
                end
                `MMU_DMA_SEG_OFS: begin
                    hit_dma_seg = 1'b1;
                end
                default: begin
                    hit_code_seg = 1'b0;
                end
            endcase
        end
    end

    assign any_hit = dpr_hit || hit_code_seg || hit_ext_mode ||
                     hit_irq_seg || hit_dma_seg;

    // Data page registers carry no reset; software must load them.
    always_ff @(posedge mclk_i) begin
        if (reg_wr_i && dpr_hit) begin
            data_page[dpr_idx] <= reg_wdata_i;
        end
    end

    // Interrupt segment register, not reset.
    always_ff @(posedge mclk_i) begin
        if (reg_wr_i && hit_irq_seg) begin
            interrupt_segment <= reg_wdata_i[`MMU_SEG_W-1:0];
        end
    end

    // DMA segment register, not reset.
    always_ff @(posedge mclk_i) begin
        if (reg_wr_i && hit_dma_seg) begin
            dma_segment <= reg_wdata_i[`MMU_SEG_W-1:0];
        end
    end

    // Extended mode control bits.
    always_comb begin
        next_reloc = page_register_relocation_bit;
        if (reg_wr_i && hit_ext_mode) begin
            next_reloc = reg_wdata_i[`MMU_RELOC_BIT];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            page_register_relocation_bit <= 1'b0;
        end else begin
            page_register_relocation_bit <= next_reloc;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            interrupt_segment_push_bit <= 1'b0;
        end else if (reg_wr_i && hit_ext_mode) begin
            interrupt_segment_push_bit <= reg_wdata_i[`MMU_PUSH_BIT];
        end
    end

    // Interrupt context tracking; nesting is not counted, so a nested
    // compatible interrupt returns to normal on the first return.
    always_comb begin
        next_ctx = ctx;
        case (ctx)
            mmu_pkg::MMU_CTX_NORMAL: begin
                if (irq_entry_i) begin
                    if (interrupt_segment_push_bit) begin
                        next_ctx = mmu_pkg::MMU_CTX_IRQ_PUSHED;
                    end else begin
                        next_ctx = mmu_pkg::MMU_CTX_IRQ_COMPAT;
                    end
                end
            end
            mmu_pkg::MMU_CTX_IRQ_COMPAT: begin
                if (iret_i) begin
                    next_ctx = mmu_pkg::MMU_CTX_NORMAL;
                end
            end
            mmu_pkg::MMU_CTX_IRQ_PUSHED: begin
                if (iret_i) begin
                    next_ctx = mmu_pkg::MMU_CTX_NORMAL;
                end
            end
            default: begin
                next_ctx = mmu_pkg::MMU_CTX_NORMAL;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            ctx <= mmu_pkg::MMU_CTX_NORMAL;
        end else begin
            ctx <= next_ctx;
        end
    end

    // Code segment update; instruction events outrank software writes,
    // since a write during normal code would tear an opcode fetch.
    always_comb begin
        next_code_segment = code_segment;
        if (reg_wr_i && hit_code_seg) begin
            next_code_segment = reg_wdata_i[`MMU_SEG_W-1:0];
        end
        if (far_load_i) begin
            next_code_segment = far_seg_i;
        end
        if (irq_entry_i && interrupt_segment_push_bit) begin
            next_code_segment = interrupt_segment;
        end
        if (iret_i && ctx == mmu_pkg::MMU_CTX_IRQ_PUSHED) begin
            next_code_segment = iret_seg_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            code_segment <= `MMU_CODE_SEG_RESET;
        end else begin
            code_segment <= next_code_segment;
        end
    end

    // Push of the old code segment on interrupt entry.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            seg_push_o <= 1'b0;
        end else begin
            seg_push_o <= irq_entry_i && interrupt_segment_push_bit;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            seg_push_val_o <= `MMU_CODE_SEG_RESET;
        end else if (irq_entry_i) begin
            seg_push_val_o <= code_segment;
        end
    end

    // Program-memory data mode set by spm, cleared by sdm.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            pmem_data_mode <= 1'b0;
        end else if (spm_i) begin
            pmem_data_mode <= 1'b1;
        end else if (sdm_i) begin
            pmem_data_mode <= 1'b0;
        end
    end

    // Read data; reserved top bits of segment registers read as zero.
    always_comb begin
        next_rdata = 8'h00;
        case ({dpr_hit, hit_code_seg, hit_ext_mode, hit_irq_seg, hit_dma_seg})
            5'h10: begin
                next_rdata = data_page[dpr_idx];
            end
            5'h08: begin
                next_rdata = {2'h0, code_segment};
            end
            5'h04: begin
                next_rdata[`MMU_RELOC_BIT] = page_register_relocation_bit;
                next_rdata[`MMU_PUSH_BIT] = interrupt_segment_push_bit;
            end
            5'h02: begin
                next_rdata = {2'h0, interrupt_segment};
            end
            5'h01: begin
                next_rdata = {2'h0, dma_segment};
            end
            default: begin
                next_rdata = 8'h00;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            reg_hit_o <= 1'b0;
        end else begin
            reg_hit_o <= (reg_rd_i || reg_wr_i) && any_hit;
        end
    end

    // Idle cycles and misses read zero, so several sources can be ORed.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= `MMU_RDATA_RESET;
        end else if (reg_rd_i && any_hit) begin
            reg_rdata_o <= next_rdata;
        end else begin
            reg_rdata_o <= `MMU_RDATA_RESET;
        end
    end

    // Translator operands.
    assign xlc.kind = acc_kind_i;
    assign xlc.vaddr = acc_vaddr_i;
    assign xlc.data_page = data_page;
    assign xlc.code_segment = code_segment;
    assign xlc.interrupt_segment = interrupt_segment;
    assign xlc.dma_segment = dma_segment;
    assign xlc.dma_page_select = dma_page_select_i;
    assign xlc.pmem_data_mode = pmem_data_mode;
    assign xlc.irq_compat = (ctx == mmu_pkg::MMU_CTX_IRQ_COMPAT);

    mmu_xlate i_mmu_xlate (
        .xl(xlc.xl)
    );

    // One register stage: the address is ready for the next memory cycle.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            phys_valid_o <= 1'b0;
        end else begin
            phys_valid_o <= acc_valid_i;
        end
    end

    // Address outputs hold between requests.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            phys_addr_o <= {`MMU_PADDR_W{1'b0}};
            phys_segment_o <= `MMU_CODE_SEG_RESET;
        end else if (acc_valid_i) begin
            // One flat space; the segment number alone picks memory.
            phys_addr_o <= xlc.paddr;
            phys_segment_o <= xlc.paddr[`MMU_PADDR_W-1:
                                        `MMU_VADDR_W];
        end
    end

    // Status outputs track their registers in the same edge.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            page_reloc_o <= 1'b0;
        end else begin
            page_reloc_o <= next_reloc;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            code_segment_o <= `MMU_CODE_SEG_RESET;
        end else begin
            code_segment_o <= next_code_segment;
        end
    end
endmodule

// ===== tb/mmu_top_properties.sv
// Port checks for the memory management unit.
`timescale 1ns/1ps
`include "mmu_defs.svh"
module mmu_top_properties (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Access and result
    input wire logic acc_valid_i,
    input wire mmu_pkg::mmu_kind_t acc_kind_i,
    input wire logic [`MMU_VADDR_W-1:0] acc_vaddr_i,
    input wire logic phys_valid_o,
    input wire logic [`MMU_PADDR_W-1:0] phys_addr_o,
    input wire logic [`MMU_SEG_W-1:0] phys_segment_o,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [5:0] reg_page_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic reg_hit_o,
    // Events and status
    input wire logic far_load_i,
    input wire logic [`MMU_SEG_W-1:0] far_seg_i,
    input wire logic irq_entry_i,
    input wire logic iret_i,
    input wire logic [`MMU_SEG_W-1:0] seg_push_val_o,
    input wire logic page_reloc_o,
    input wire logic [`MMU_SEG_W-1:0] code_segment_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);
    AST_VALID_ONE: assert property (acc_valid_i |=> phys_valid_o)
        else $error("access not answered next cycle");
    AST_VALID_IDLE: assert property (!acc_valid_i |=> !phys_valid_o)
        else $error("result valid without access");
    AST_SEG_FIELD: assert property (phys_segment_o == phys_addr_o[21:16])
        else $error("segment output differs from address top");
    AST_PAGE_OFFSET: assert property (acc_valid_i &&
        acc_kind_i == mmu_pkg::MMU_KIND_DATA
        |=> phys_addr_o[13:0] == $past(acc_vaddr_i[13:0]))
        else $error("page offset altered");
    AST_SEG_LOW: assert property (acc_valid_i &&
        acc_kind_i != mmu_pkg::MMU_KIND_DATA
        |=> phys_addr_o[15:0] == $past(acc_vaddr_i))
        else $error("segment offset altered");
    AST_PMEM_CS: assert property (acc_valid_i &&
        acc_kind_i == mmu_pkg::MMU_KIND_PMEM_DATA
        |=> phys_segment_o == $past(code_segment_o))
        else $error("program data not in code segment");
    AST_CS_READ: assert property (reg_rd_i &&
        reg_page_i == `MMU_MMU_PAGE && reg_addr_i == `MMU_CODE_SEG_OFS
        |=> reg_hit_o && reg_rdata_o == {2'h0, $past(code_segment_o)})
        else $error("code segment read wrong");
    AST_FAR_LOAD: assert property (far_load_i && !irq_entry_i &&
        !iret_i && !reg_wr_i |=> code_segment_o == $past(far_seg_i))
        else $error("far load not taken");
    AST_REG_QUIET: assert property (!reg_rd_i && !reg_wr_i
        |=> !reg_hit_o && reg_rdata_o == 8'h00)
        else $error("register answer without strobe");
    AST_RELOC: assert property (reg_wr_i &&
        reg_page_i == `MMU_MMU_PAGE && reg_addr_i == `MMU_EXT_MODE_OFS
        |=> page_reloc_o == $past(reg_wdata_i[5]))
        else $error("relocation bit not stored");
    AST_PUSH_VAL: assert property (irq_entry_i
        |=> seg_push_val_o == $past(code_segment_o))
        else $error("pushed segment wrong");
    AST_CS_RESET: assert property ($rose(rst_n_i) |-> code_segment_o == 6'h00)
        else $error("code segment not cleared by reset");
    cover property (acc_valid_i && acc_kind_i == mmu_pkg::MMU_KIND_DMA);
    cover property (irq_entry_i ##[1:40] iret_i);
    cover property (page_reloc_o && acc_valid_i);
endmodule
bind mmu_top mmu_top_properties i_mmu_top_properties (.mclk_i(mclk_i),
    .rst_n_i(rst_n_i), .acc_valid_i(acc_valid_i), .acc_kind_i(acc_kind_i),
    .acc_vaddr_i(acc_vaddr_i), .phys_valid_o(phys_valid_o),
    .phys_addr_o(phys_addr_o), .phys_segment_o(phys_segment_o),
    .reg_addr_i(reg_addr_i), .reg_page_i(reg_page_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .reg_hit_o(reg_hit_o),
    .far_load_i(far_load_i), .far_seg_i(far_seg_i),
    .irq_entry_i(irq_entry_i), .iret_i(iret_i),
    .seg_push_val_o(seg_push_val_o), .page_reloc_o(page_reloc_o),
    .code_segment_o(code_segment_o));

// ===== tb/mmu_core_model.sv
// Core address generator model issuing tagged accesses.
`timescale 1ns/1ps
module mmu_core_model (
    // Clock
    input wire logic clk_i,
    // Access request
    output logic acc_valid_o,
    output mmu_pkg::mmu_kind_t acc_kind_o,
    output logic [15:0] acc_vaddr_o,
    // Translated result
    input wire logic phys_valid_i,
    input wire logic [21:0] phys_addr_i
);
    initial begin
        acc_valid_o = 1'b0;
        acc_kind_o = mmu_pkg::MMU_KIND_FETCH;
        acc_vaddr_o = 16'h0000;
    end
    // The released address is inverted so stale values never match.
    task automatic access(input mmu_pkg::mmu_kind_t k,
        input logic [15:0] va, output logic [22:0] res);
        @(negedge clk_i);
        acc_valid_o = 1'b1;
        acc_kind_o = k;
        acc_vaddr_o = va;
        @(negedge clk_i);
        acc_valid_o = 1'b0;
        acc_vaddr_o = ~va;
        res = {phys_valid_i, phys_addr_i};
    endtask
endmodule

// ===== tb/mmu_address_extension_tb_top.sv
// Self-checking testbench of the memory management unit.
`timescale 1ns/1ps
module mmu_address_extension_tb_top;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic acc_valid_i, phys_valid_o, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    mmu_pkg::mmu_kind_t acc_kind_i;
    logic [15:0] acc_vaddr_i;
    logic [21:0] phys_addr_o;
    logic [5:0] phys_segment_o, reg_page_i = 6'h00, far_seg_i = 6'h00;
    logic [5:0] iret_seg_i = 6'h00, seg_push_val_o, code_segment_o;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
    logic reg_hit_o, seg_push_o, page_reloc_o, dma_page_select_i = 1'b0;
    logic far_load_i = 1'b0, irq_entry_i = 1'b0, iret_i = 1'b0;
    logic spm_i = 1'b0, sdm_i = 1'b0;
    int n_errors = 0;
    int checked = 0;
    mmu_top i_mmu_top (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .acc_valid_i(acc_valid_i), .acc_kind_i(acc_kind_i),
        .acc_vaddr_i(acc_vaddr_i), .phys_valid_o(phys_valid_o),
        .phys_addr_o(phys_addr_o), .phys_segment_o(phys_segment_o),
        .reg_addr_i(reg_addr_i), .reg_page_i(reg_page_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .reg_hit_o(reg_hit_o),
        .far_load_i(far_load_i), .far_seg_i(far_seg_i),
        .irq_entry_i(irq_entry_i), .iret_i(iret_i), .iret_seg_i(iret_seg_i),
        .spm_i(spm_i), .sdm_i(sdm_i), .dma_page_select_i(dma_page_select_i),
        .seg_push_o(seg_push_o), .seg_push_val_o(seg_push_val_o),
        .page_reloc_o(page_reloc_o), .code_segment_o(code_segment_o));
    mmu_core_model i_mmu_core_model (.clk_i(mclk_i),
        .acc_valid_o(acc_valid_i), .acc_kind_o(acc_kind_i),
        .acc_vaddr_o(acc_vaddr_i), .phys_valid_i(phys_valid_o),
        .phys_addr_i(phys_addr_o));
    initial begin
        forever #5 mclk_i = ~mclk_i;
    end
    task automatic check(input string what, input logic [23:0] seen,
        input logic [23:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude;
        if (n_errors == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [5:0] p,
        input logic [7:0] d);
        @(negedge mclk_i);
        {reg_addr_i, reg_page_i, reg_wdata_i, reg_wr_i} = {a, p, d, 1'b1};
        @(negedge mclk_i);
        reg_wr_i = 1'b0;
        reg_wdata_i = ~d;
    endtask
    // Expected value is {hit, data}; misses must read as zero.
    task automatic rd(input logic [7:0] a, input logic [5:0] p,
        input logic [8:0] exp);
        @(negedge mclk_i);
        {reg_addr_i, reg_page_i, reg_rd_i} = {a, p, 1'b1};
        @(negedge mclk_i);
        reg_rd_i = 1'b0;
        check("register read", {reg_hit_o, reg_rdata_o}, exp);
    endtask
    task automatic acc(input mmu_pkg::mmu_kind_t k, input logic [15:0] va,
        input logic [21:0] exp);
        logic [22:0] res;
        i_mmu_core_model.access(k, va, res);
        check("physical address", res, {1'b1, exp});
        check("segment", phys_segment_o, exp[21:16]);
    endtask
    // Bits are far load, entry, return, spm, sdm.
    task automatic ev(input logic [4:0] e);
        @(negedge mclk_i);
        {far_load_i, irq_entry_i, iret_i, spm_i, sdm_i} = e;
        @(negedge mclk_i);
        {far_load_i, irq_entry_i, iret_i, spm_i, sdm_i} = 5'h00;
    endtask
    task automatic s_reset;
        rd(8'hF4, 6'h15, 9'h100);
        rd(8'hF6, 6'h15, 9'h100);
        acc(mmu_pkg::MMU_KIND_FETCH, 16'h1234, 22'h001234);
    endtask
    task automatic s_pages;
        logic [7:0] pg;
        for (int i = 0; i < 4; i++) begin
            pg = 8'(8'h81 + 8'h3E * i);
            wr(8'(8'hF0 + i), 6'h15, pg);
            rd(8'(8'hF0 + i), 6'h15, {1'b1, pg});
            acc(mmu_pkg::MMU_KIND_DATA, {2'(i), 14'h0000}, {pg, 14'h0});
            acc(mmu_pkg::MMU_KIND_DATA, {2'(i), 14'h3FFF}, {pg, 14'h3FFF});
        end
    endtask
    task automatic s_reloc;
        wr(8'hF6, 6'h15, 8'h20);
        check("relocation", page_reloc_o, 24'h1);
        wr(8'hF0, 6'h15, 8'h00);
        rd(8'hF0, 6'h15, 9'h000);
        wr(8'hE2, 6'h03, 8'h5C);
        rd(8'hE2, 6'h00, 9'h15C);
        acc(mmu_pkg::MMU_KIND_DATA, 16'h8010, {8'h5C, 14'h0010});
        wr(8'hF6, 6'h15, 8'h00);
        acc(mmu_pkg::MMU_KIND_DATA, 16'h0010, {8'h81, 14'h0010});
        rd(8'hF5, 6'h15, 9'h000);
        rd(8'hF8, 6'h14, 9'h000);
    endtask
    task automatic s_code;
        wr(8'hF4, 6'h15, 8'hFF);
        rd(8'hF4, 6'h15, 9'h13F);
        far_seg_i = 6'h02;
        ev(5'h10);
        check("code segment", code_segment_o, 24'h02);
        acc(mmu_pkg::MMU_KIND_FETCH, 16'hABCD, {6'h02, 16'hABCD});
        acc(mmu_pkg::MMU_KIND_PMEM_DATA, 16'h4000, {6'h02, 16'h4000});
        ev(5'h02);
        acc(mmu_pkg::MMU_KIND_DATA, 16'h4000, {6'h02, 16'h4000});
        ev(5'h01);
        acc(mmu_pkg::MMU_KIND_DATA, 16'h4000, {8'hBF, 14'h0000});
    endtask
    task automatic s_irq_dma;
        wr(8'hF8, 6'h15, 8'h07);
        wr(8'hF9, 6'h15, 8'h09);
        rd(8'hF9, 6'h15, 9'h109);
        dma_page_select_i = 1'b1;
        acc(mmu_pkg::MMU_KIND_DMA, 16'h0100, {6'h09, 16'h0100});
        dma_page_select_i = 1'b0;
        acc(mmu_pkg::MMU_KIND_DMA, 16'h0100, {6'h07, 16'h0100});
        ev(5'h08);
        check("no push", seg_push_o, 24'h0);
        acc(mmu_pkg::MMU_KIND_IRQ_FETCH, 16'h0040, {6'h07, 16'h0040});
        acc(mmu_pkg::MMU_KIND_FETCH, 16'h0042, {6'h07, 16'h0042});
        ev(5'h04);
        acc(mmu_pkg::MMU_KIND_FETCH, 16'h0044, {6'h02, 16'h0044});
        wr(8'hF6, 6'h15, 8'h40);
        ev(5'h08);
        check("push", {seg_push_o, seg_push_val_o, code_segment_o},
            {1'b1, 6'h02, 6'h07});
        acc(mmu_pkg::MMU_KIND_FETCH, 16'h0046, {6'h07, 16'h0046});
        iret_seg_i = 6'h02;
        ev(5'h04);
        check("restore", code_segment_o, 24'h02);
        wr(8'hF6, 6'h15, 8'h00);
    endtask
    initial begin
        repeat (2) @(negedge mclk_i);
        rst_n_i = 1'b1;
        s_reset();
        s_pages();
        s_reloc();
        s_code();
        s_irq_dma();
        conclude();
    end
    initial begin
        repeat (20000) @(posedge mclk_i);
        n_errors++;
        conclude();
    end
endmodule
